// *** hw/rpf_top.sv ***
// radio payload queues, pipe 4/5 payload widths and queue state
// serial port runs on its own clock; the radio core sits on i_sys_clk
// Notes on behaviour
// RULE1: pipe 4 width is six bits, zero unused, one to 32 bytes
// RULE2: pipe 5 width is six bits, resets zero, top two bits read zero
// RULE3: resend command sets the read-only reuse bit
// RULE4: reuse holds until a transmit write or transmit flush clears it
// RULE5: controller holds chip enable high ten microseconds to resend
// RULE6: status bit five shows transmit queue full, resets zero
// RULE7: status bit four shows transmit queue empty, resets one
// RULE8: status bit one shows receive queue full, resets zero
// RULE9: status bit zero shows receive queue empty, resets one
// RULE10: ack payloads load by pipe-tagged command, receiver mode only
// RULE11: at most three ack payloads pending across all pipes
// RULE12: ack payloads for one pipe are served oldest first
// RULE13: transmit queue holds three payloads, written by command, tx mode
// RULE14: one shared three-entry receive queue, read by command
// RULE15: payload write to a full queue is ignored
`timescale 1ns/1ns
`default_nettype none
`include "rpf_consts.svh"

module rpf_top
  import rpf_pkg::*;
#(
  parameter int DEPTH = `RPF_DEPTH
)(
  // system
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // serial port
  input  wire logic         i_spi_clk,
  input  wire logic         i_spi_cs_n,
  input  wire logic         i_spi_mosi,
  output logic              o_spi_miso,
  // radio mode and widths
  input  wire logic         i_rx_mode,
  output logic [5:0]        o_pipe4_width,
  output logic [5:0]        o_pipe5_width,
  // transmit side
  input  wire logic         i_tx_sent,
  output logic              o_tx_valid,
  output logic [5:0]        o_tx_len,
  output logic [255:0]      o_tx_data,
  output logic              o_tx_reuse,
  // receive side
  input  wire logic         i_rx_push,
  input  wire logic [5:0]   i_rx_len,
  input  wire logic [255:0] i_rx_data,
  // acknowledge side
  input  wire logic [2:0]   i_ack_pipe,
  input  wire logic         i_ack_take,
  output logic              o_ack_valid,
  output logic [5:0]        o_ack_len,
  output logic [255:0]      o_ack_data
);

  localparam int NW = $clog2(DEPTH + 1);
  localparam logic [NW-1:0] FULLN = NW'(DEPTH);
  localparam logic [NW-1:0] ONEN  = NW'(1);

  //////////////////////////////////////////////////////////////////////
  // serial clock domain

  typedef struct packed {
    logic [7:0]   sh;
    logic [7:0]   cmd;
    logic [255:0] pay;
    logic [5:0]   nb;
    logic         tgl;
    logic         miso;
  } spi_s;

  typedef struct packed {
    logic [1:0]                cs_sync;
    logic                      cs_prev;
    logic                      seen;
    logic [5:0]                p4;
    logic [5:0]                p5;
    logic                      reuse;
    logic [7:0]                snap;
    logic [NW-1:0]             tx_n;
    logic [NW-1:0]             rx_n;
    logic [NW-1:0]             ack_n;
    rpf_pld_s [DEPTH-1:0]      tx;
    rpf_pld_s [DEPTH-1:0]      rx;
    rpf_ack_s [DEPTH-1:0]      ack;
    logic                      ack_hit;
    logic [NW-1:0]             ack_idx;
    logic                      tx_v;
    rpf_pld_s                  ack_out;
  } sys_s;

  spi_s       s_q;
  spi_s       s_d;
  sys_s       q;
  sys_s       d;
  logic [8:0] cnt_q;
  logic [7:0] qs;

  // register read-back shared by the reply path
  function automatic logic [7:0] reg_read(input logic [4:0] a,
                                          input sys_s r,
                                          input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `RPF_ADDR_P4:     v = {2'b00, r.p4};
      `RPF_ADDR_P5:     v = {2'b00, r.p5};
      `RPF_ADDR_QSTATE: v = st;
      default:          v = 8'h00;
    endcase
    return v;
  endfunction

  // bit counter restarts with every frame
  always_ff @(posedge i_spi_clk or posedge i_spi_cs_n)
  begin
    if (i_spi_cs_n)
      cnt_q <= 9'h000;
    else if (cnt_q != 9'h1ff)
      cnt_q <= cnt_q + 9'h001;
  end

  always_comb
  begin
    logic [7:0] byt;
    logic [7:0] cmdv;
    logic [8:0] nxt;
    logic [5:0] k;
    logic [7:0] rb;
    byt  = {s_q.sh[6:0], i_spi_mosi};
    cmdv = (cnt_q == 9'h007) ? byt : s_q.cmd;
    nxt  = cnt_q + 9'h001;
    k    = nxt[8:3];
    rb   = 8'h00;
    s_d  = s_q;
    s_d.sh = byt;
    if (cnt_q[2:0] == 3'h7)
    begin
      if (cnt_q[8:3] == 6'h00)
      begin
        s_d.cmd = byt;
        s_d.nb  = 6'h00;
        s_d.tgl = ~s_q.tgl;
      end
      else if (cnt_q[8:3] <= 6'(`RPF_MAX_BYTES))
      begin
        s_d.pay[{cnt_q[7:3] - 5'h01, 3'h0} +: 8] = byt;
        s_d.nb = cnt_q[8:3];
      end
    end
    // reply stream: queue state, then register or receive payload
    if (k == 6'h00)
      rb = q.snap;
    else if (cmdv[7:5] == `RPF_CMD_RREG)
      rb = reg_read(cmdv[4:0], q, q.snap);
    else if (cmdv == `RPF_CMD_RRX && k <= 6'(`RPF_MAX_BYTES)) // RULE14
      rb = q.rx[0].data[{k[4:0] - 5'h01, 3'h0} +: 8];
    s_d.miso = rb[3'h7 - nxt[2:0]];
  end

  always_ff @(posedge i_spi_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_spi_miso = s_q.miso;

  //////////////////////////////////////////////////////////////////////
  // system clock domain

  assign qs = {1'b0,
               q.reuse,                                   // RULE3
               q.tx_n == FULLN,                           // RULE6
               q.tx_n == '0,                              // RULE7
               2'b00,
               q.rx_n == FULLN,                           // RULE8
               q.rx_n == '0};                             // RULE9

  always_comb
  begin
    logic go;
    logic fnd;
    go  = q.cs_sync[1] && !q.cs_prev && (s_q.tgl != q.seen);
    fnd = 1'b0;
    d = q;
    d.cs_sync = {q.cs_sync[0], i_spi_cs_n};
    d.cs_prev = q.cs_sync[1];
    // frozen while a frame runs so the serial side sees a steady word
    if (q.cs_sync[1])
      d.snap = qs;
    // transmit done: head stays while reuse is active
    if (i_tx_sent && q.tx_n != '0 && !q.reuse)             // RULE4
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        d.tx[i] = d.tx[i+1];
      d.tx_n = d.tx_n - ONEN;
    end
    // received packet: dropped when the shared queue is full
    if (i_rx_push && d.rx_n != FULLN)                      // RULE14
    begin
      d.rx[d.rx_n] = '{len: i_rx_len, data: i_rx_data};
      d.rx_n = d.rx_n + ONEN;
    end
    // acknowledge payload used by the radio
    if (i_ack_take && q.ack_hit)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        if (NW'(i) >= q.ack_idx)
          d.ack[i] = d.ack[i+1];
      d.ack_n = d.ack_n - ONEN;
    end
    // frame ends: run the command once, stale frames are skipped
    if (go)
    begin
      d.seen = s_q.tgl;
      if (s_q.cmd[7:5] == `RPF_CMD_WREG && s_q.nb != 6'h00)
      begin
        if (s_q.cmd[4:0] == `RPF_ADDR_P4)
          d.p4 = s_q.pay[5:0];                              // RULE1
        if (s_q.cmd[4:0] == `RPF_ADDR_P5)
          d.p5 = s_q.pay[5:0];                              // RULE2
      end
      else if (s_q.cmd == `RPF_CMD_WTX)
      begin
        d.reuse = 1'b0;                                     // RULE4
        if (!i_rx_mode && s_q.nb != 6'h00 && d.tx_n != FULLN) // RULE13
        begin
          d.tx[d.tx_n] = '{len: s_q.nb, data: s_q.pay};
          d.tx_n = d.tx_n + ONEN;
        end                                                 // RULE15
      end
      else if (s_q.cmd == `RPF_CMD_FLTX)
      begin
        d.tx_n  = '0;
        d.reuse = 1'b0;                                     // RULE4
      end
      else if (s_q.cmd == `RPF_CMD_FLRX)
        d.rx_n = '0;
      else if (s_q.cmd == `RPF_CMD_REUSE)
        d.reuse = 1'b1;                                     // RULE3
      else if (s_q.cmd == `RPF_CMD_RRX && d.rx_n != '0)     // RULE14
      begin
        for (int i = 0; i < DEPTH - 1; i++)
          d.rx[i] = d.rx[i+1];
        d.rx_n = d.rx_n - ONEN;
      end
      else if (s_q.cmd[7:3] == `RPF_CMD_WACK)               // RULE10
      begin
        if (i_rx_mode && s_q.nb != 6'h00 && d.ack_n != FULLN) // RULE11
        begin
          d.ack[d.ack_n] = '{pipe: s_q.cmd[2:0],
                             pld: '{len: s_q.nb, data: s_q.pay}};
          d.ack_n = d.ack_n + ONEN;
        end                                                 // RULE15
      end
    end
    // oldest pending entry for the pipe the radio asks about
    d.ack_idx = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
      if (NW'(i) < d.ack_n && d.ack[i].pipe == i_ack_pipe)  // RULE12
      begin
        fnd = 1'b1;
        d.ack_idx = NW'(i);
      end
    d.ack_hit = fnd;
    // registered copies so the outputs leave straight from flops
    d.tx_v    = d.tx_n != '0;
    d.ack_out = d.ack[d.ack_idx].pld;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q         <= '0;
      q.cs_sync <= 2'b11;
      q.cs_prev <= 1'b1;
      q.p4      <= `RPF_WIDTH_RST;                          // RULE1
      q.p5      <= `RPF_WIDTH_RST;                          // RULE2
      q.snap    <= `RPF_QS_RST;
    end
    else
      q <= d;
  end

  assign o_pipe4_width = q.p4;
  assign o_pipe5_width = q.p5;
  assign o_tx_valid    = q.tx_v;
  assign o_tx_len      = q.tx[0].len;
  assign o_tx_data     = q.tx[0].data;
  assign o_tx_reuse    = q.reuse;
  assign o_ack_valid   = q.ack_hit;
  assign o_ack_len     = q.ack_out.len;
  assign o_ack_data    = q.ack_out.data;

endmodule // rpf_top
`default_nettype wire

// *** hw/rpf_consts.svh ***
// constants for the radio payload queue and queue-state block
// assumes inclusion by the block top and the bench only
`ifndef RPF_CONSTS_SVH
`define RPF_CONSTS_SVH
// register addresses, 5-bit field of the register commands
`define RPF_ADDR_P4      5'h15
`define RPF_ADDR_P5      5'h16
`define RPF_ADDR_QSTATE  5'h17
// queue_state field positions and reset value
`define RPF_QS_REUSE     6
`define RPF_QS_TX_FULL   5
`define RPF_QS_TX_EMPTY  4
`define RPF_QS_RX_FULL   1
`define RPF_QS_RX_EMPTY  0
`define RPF_QS_RST       8'h11
`define RPF_WIDTH_RST    6'h00
// serial command codes
`define RPF_CMD_RREG     3'h0
`define RPF_CMD_WREG     3'h1
`define RPF_CMD_WTX      8'ha0
`define RPF_CMD_RRX      8'h61
`define RPF_CMD_FLTX     8'he1
`define RPF_CMD_FLRX     8'he2
`define RPF_CMD_REUSE    8'he3
`define RPF_CMD_WACK     5'h15
// queue depth and payload size
`define RPF_DEPTH        3
`define RPF_MAX_BYTES    32
// chip enable hold before a resend: 10 us at 50 ns per system clock
`define RPF_REUSE_CE_CYC 200
`endif

// *** hw/rpf_pkg.sv ***
// types shared by the radio payload queue block
// assumes nothing beyond the constants header
`default_nettype none
package rpf_pkg;
  // one queued payload: byte count and up to 32 bytes, byte 0 lowest
  typedef struct packed {
    logic [5:0]   len;
    logic [255:0] data;
  } rpf_pld_s;

  // acknowledge payload tagged with its target pipe
  typedef struct packed {
    logic [2:0] pipe;
    rpf_pld_s   pld;
  } rpf_ack_s;
endpackage
`default_nettype wire

// *** dv/rpf_spi_host.sv ***
// serial host model: the controller side of the payload queue block
// assumes mosi is sampled on rising sclk and miso shifts after it
`timescale 1ns/1ns
`default_nettype none
module rpf_spi_host (
  // serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  logic [7:0] tx_b [0:33];
  logic [7:0] rx_b [0:33];
  initial
  begin
    o_sclk = 1'b0;
    o_mosi = 1'b1;
    // a clean rising select clears the bit counter before frame one
    o_cs_n = 1'b0;
    #1 o_cs_n = 1'b1;
  end
  // sclk only runs inside a frame; msb first
  task automatic xfer(input int n);
    // reply lags one bit: position 0 is never shown, reserved zero
    rx_b[0][7] = 1'b0;
    for (int i = 0; i < 8 * n; i++)
    begin
      o_mosi = tx_b[i / 8][7 - i % 8];
      o_cs_n = 1'b0;
      #7 o_sclk = 1'b1;
      #8 o_sclk = 1'b0;
      rx_b[(i + 1) / 8][7 - (i + 1) % 8] = i_miso;
    end
    #7 o_mosi = ~o_mosi;
    o_cs_n = 1'b1;
    // long gap so the command lands before the next frame
    #600;
  endtask
endmodule // rpf_spi_host
`default_nettype wire

// *** dv/rpf_top_props.sv ***
// assertions on rpf_top ports, system clock domain
// assumes binding into every rpf_top instance
`timescale 1ns/1ns
`default_nettype none
module rpf_top_props (
  // watched ports
  input wire logic         i_sys_clk,
  input wire logic         i_rst_n,
  input wire logic         i_spi_cs_n,
  input wire logic         i_rx_mode,
  input wire logic         i_tx_sent,
  input wire logic [2:0]   i_ack_pipe,
  input wire logic         i_ack_take,
  input wire logic [5:0]   o_pipe4_width,
  input wire logic [5:0]   o_pipe5_width,
  input wire logic         o_tx_valid,
  input wire logic [255:0] o_tx_data,
  input wire logic         o_tx_reuse,
  input wire logic         o_ack_valid
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // commands act only once the frame has closed
  sequence s_landed;
    $past(i_spi_cs_n, 2);
  endsequence

  AST_RST_VAL: assert property ($rose(i_rst_n) |->
    o_pipe5_width == 6'h00 && !o_tx_valid) else $error("bad reset value");
  AST_W4_HOLD: assert property (!$stable(o_pipe4_width) |-> s_landed)
    else $error("pipe4 width moved");
  AST_REUSE_SET: assert property ($rose(o_tx_reuse) |-> s_landed)
    else $error("reuse set outside a command");
  AST_REUSE_CLR: assert property ($fell(o_tx_reuse) |-> s_landed)
    else $error("reuse cleared outside a command");
  AST_REUSE_HOLD: assert property (o_tx_reuse && o_tx_valid && i_tx_sent
    |=> o_tx_valid && $stable(o_tx_data)) else $error("reused head popped");
  AST_TX_RISE: assert property ($rose(o_tx_valid)
    |-> s_landed ##0 !$past(i_rx_mode)) else $error("tx filled in rx mode");
  AST_TX_FALL: assert property ($fell(o_tx_valid) |->
    $past(i_tx_sent) || $past(i_tx_sent, 2) || $past(i_spi_cs_n, 2))
    else $error("tx emptied without cause");
  AST_ACK_KEEP: assert property (o_ack_valid && !i_ack_take
    && !$past(i_ack_take) && $stable(i_ack_pipe) |=> o_ack_valid)
    else $error("ack entry lost");
endmodule // rpf_top_props
bind rpf_top rpf_top_props u_props (.*);
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the payload queue block
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "rpf_consts.svh"
module tb_top;
  logic         i_sys_clk = 1'b0;
  logic         i_rst_n = 1'b0;
  logic         sclk, cs_n, mosi, miso, tx_v, tx_r, ack_v;
  logic         i_rx_mode, i_tx_sent, i_rx_push, i_ack_take;
  logic [5:0]   i_rx_len, p4w, tx_l, ack_l;
  logic [2:0]   i_ack_pipe;
  logic [255:0] i_rx_data, tx_d, ack_d;
  logic [255:0] ex [0:2];
  int           ln [0:2];
  logic [5:0]   wv [0:3];
  int           bad_count = 0;
  int           n_compared = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  rpf_spi_host h (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
  rpf_top DUT (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_spi_clk(sclk),
    .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .i_rx_mode(i_rx_mode), .o_pipe4_width(p4w), .o_pipe5_width(),
    .i_tx_sent(i_tx_sent), .o_tx_valid(tx_v), .o_tx_len(tx_l),
    .o_tx_data(tx_d), .o_tx_reuse(tx_r), .i_rx_push(i_rx_push),
    .i_rx_len(i_rx_len), .i_rx_data(i_rx_data), .i_ack_pipe(i_ack_pipe),
    .i_ack_take(i_ack_take), .o_ack_valid(ack_v), .o_ack_len(ack_l),
    .o_ack_data(ack_d));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [255:0] seen, logic [255:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [255:0] mk(int n);
    return (256'h1 << 8 * n) - 256'h1;
  endfunction
  function automatic logic [255:0] pk(logic [7:0] b [0:33], int n);
    pk = '0;
    for (int i = 0; i < n; i++)
      pk[8 * i +: 8] = b[i + 1];
  endfunction
  task automatic cmd(logic [7:0] c, int n);
    h.tx_b[0] = c;
    h.xfer(n + 1);
  endtask
  task automatic rd(logic [4:0] a);
    cmd({`RPF_CMD_RREG, a}, 1);
  endtask
  task automatic fill(int n);
    for (int i = 1; i <= n; i++)
      h.tx_b[i] = 8'($urandom());
  endtask
  task automatic tick(ref logic s);
    @(negedge i_sys_clk) s = 1'b1;
    @(negedge i_sys_clk) s = 1'b0;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #2_000_000;
    bad_count++;
    end_of_test;
  end
  initial
  begin
    int n;
    {i_rx_mode, i_tx_sent, i_rx_push, i_ack_take} = 4'h0;
    {i_ack_pipe, i_rx_len, i_rx_data} = '0;
    void'($urandom(94));
    repeat (10) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    rd(`RPF_ADDR_P5);
    check("state", h.rx_b[0], `RPF_QS_RST);
    check("p5", h.rx_b[1], 8'h00);
    $display("reset test done");
    wv = '{6'h00, 6'h01, 6'h20, 6'($urandom_range(2, 31))};
    foreach (wv[i])
    begin
      h.tx_b[1] = {2'b00, wv[i]};
      cmd({`RPF_CMD_WREG, `RPF_ADDR_P4}, 1);
      h.tx_b[1] = {2'b11, wv[i]};
      cmd({`RPF_CMD_WREG, `RPF_ADDR_P5}, 1);
      rd(`RPF_ADDR_P5);
      check("p5", h.rx_b[1], {2'b00, wv[i]});
      check("p4", p4w, wv[i]);
    end
    $display("width test done");
    @(negedge i_sys_clk) i_rx_mode = 1'b1;
    fill(4);
    cmd(`RPF_CMD_WTX, 4);
    check("tx in rx mode", tx_v, 1'b0);
    @(negedge i_sys_clk) i_rx_mode = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 0) ? 32 : $urandom_range(1, 32);
      fill(n);
      cmd(`RPF_CMD_WTX, n);
      if (k < 3) {ex[k], ln[k]} = {pk(h.tx_b, n), n};
    end
    rd(`RPF_ADDR_QSTATE);
    check("tx flags", h.rx_b[1][5:4], 2'b10);
    cmd(`RPF_CMD_REUSE, 0);
    rd(`RPF_ADDR_QSTATE);
    check("reuse", h.rx_b[1][6], 1'b1);
    // chip enable held high long enough before the resend
    repeat (`RPF_REUSE_CE_CYC) @(negedge i_sys_clk);
    tick(i_tx_sent);
    check("reused head", tx_d & mk(ln[0]), ex[0]);
    cmd(`RPF_CMD_WTX, 1);
    check("reuse off", tx_r, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      check("tx order", tx_d & mk(ln[k]), ex[k]);
      check("tx len", tx_l, ln[k]);
      tick(i_tx_sent);
    end
    check("full write", tx_v, 1'b0);
    cmd(`RPF_CMD_WTX, 1);
    cmd(`RPF_CMD_REUSE, 0);
    cmd(`RPF_CMD_FLTX, 0);
    check("flush", {tx_r, tx_v}, 2'b00);
    $display("transmit test done");
    for (int k = 0; k < 4; k++)
    begin
      @(negedge i_sys_clk);
      i_rx_len = 6'($urandom_range(1, 32));
      for (int i = 0; i < 8; i++)
        i_rx_data[32 * i +: 32] = $urandom();
      i_rx_push = 1'b1;
      if (k < 3) {ex[k], ln[k]} = {i_rx_data & mk(i_rx_len), 26'h0, i_rx_len};
      @(negedge i_sys_clk) i_rx_push = 1'b0;
    end
    rd(`RPF_ADDR_QSTATE);
    check("rx flags", h.rx_b[1][1:0], 2'b10);
    for (int k = 0; k < 3; k++)
    begin
      cmd(`RPF_CMD_RRX, 32);
      check("rx payload", pk(h.rx_b, ln[k]), ex[k]);
    end
    rd(`RPF_ADDR_QSTATE);
    check("rx drained", h.rx_b[1][1:0], 2'b01);
    $display("receive test done");
    @(negedge i_sys_clk) i_rx_mode = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      n = $urandom_range(1, 32);
      fill(n);
      cmd({`RPF_CMD_WACK, (k == 1) ? 3'h5 : 3'h2}, n);
      if (k < 3) {ex[k], ln[k]} = {pk(h.tx_b, n), n};
    end
    @(negedge i_sys_clk) i_ack_pipe = 3'h2;
    repeat (2) @(negedge i_sys_clk);
    check("ack oldest", ack_d & mk(ln[0]), ex[0]);
    check("ack len", ack_l, ln[0]);
    tick(i_ack_take);
    check("ack next", ack_d & mk(ln[2]), ex[2]);
    tick(i_ack_take);
    check("ack limit", ack_v, 1'b0);
    @(negedge i_sys_clk) i_ack_pipe = 3'h5;
    repeat (2) @(negedge i_sys_clk);
    check("ack pipe", ack_d & mk(ln[1]), ex[1]);
    $display("ack test done");
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
